// *** logic/data_memory_bus_port.sv ***
// Data memory bus port: strobes, wait states, bank and page decode, float and bus grant.
`timescale 1ns/1ns
`default_nettype none
`include "dm_port_defs.svh"

module data_memory_bus_port (
	input  wire logic                   clk,                  // Input clock, 125 MHz.
	input  wire logic                   nrst,                 // Asynchronous reset, low.
	input  wire logic                   core_req,             // Core wants an access, level.
	input  wire logic                   core_write,           // Access is a write.
	input  wire logic [`DMP_ADDR_W-1:0] core_addr,            // Word address.
	input  wire logic [`DMP_DATA_W-1:0] core_wdata,           // Write data, word in 39..8.
	input  wire logic [`DMP_SEL_W-1:0]  page_size_sel,        // Log2 of page size in words.
	input  wire logic [`DMP_SEL_W-1:0]  bank_size_sel,        // Log2 of bank size in words.
	input  wire logic                   data_mem_acknowledge, // Low adds wait states.
	input  wire logic                   data_bus_float_n,     // Low floats the bus during an access.
	input  wire logic                   bus_request_n,        // Asynchronous bus request, low.
	input  wire logic [`DMP_DATA_W-1:0] data_mem_bus_in,      // Data bus input side.
	output logic                        core_busy,            // Port cannot take a request.
	output logic                        core_done,            // Access finished, one cycle.
	output logic [`DMP_DATA_W-1:0]      core_rdata,           // Read data of last read.
	output logic [`DMP_ADDR_W-1:0]      data_mem_addr,        // Address lines.
	output logic                        data_mem_addr_oe,     // Address drive enable.
	output logic [`DMP_DATA_W-1:0]      data_mem_bus_out,     // Data bus output side.
	output logic                        data_mem_bus_oe,      // Data bus drive enable.
	output logic                        data_read_strobe_n,   // Read strobe, low.
	output logic                        data_write_strobe_n,  // Write strobe, low.
	output logic [`DMP_BANKS-1:0]       data_bank_selects_n,  // Bank selects, low.
	output logic                        data_ctl_oe,          // Strobe and select enable.
	output logic                        data_page_cross,      // Page boundary crossed.
	output logic                        bus_grant_n           // Bus grant, low.
);

	// ==========================================================
	// State record and its next value.
	localparam dm_port_pkg::port_reg_s REG_RESET = '{
		state:   dm_port_pkg::ST_IDLE,
		rd_n:    `DMP_STROBE_IDLE,
		wr_n:    `DMP_STROBE_IDLE,
		bank_n:  `DMP_BANK_IDLE,
		grant_n: `DMP_GRANT_IDLE,
		addr_oe: `DMP_OE_RESET,
		ctl_oe:  `DMP_OE_RESET,
		default: '0
	};

	dm_port_pkg::port_reg_s q;
	dm_port_pkg::port_reg_s d;

	logic                    br_sync;
	logic                    accept;
	logic                    finish;
	logic [`DMP_ADDR_W-1:0]  bank_idx;
	logic [1:0]              bank_sel;
	logic [`DMP_BANKS-1:0]   bank_n_new;
	logic                    page_new;

	// ==========================================================
	// Decode helpers.
	// The synchronised request is taken from the second stage only.
	assign br_sync = q.br_s2;

	// A request is taken only in idle and only if no bus request is pending.
	assign accept = (q.state == dm_port_pkg::ST_IDLE) && core_req && !br_sync;

	// An access ends on acknowledge, but not in a cycle where the bus is floated
	// or the drivers are still coming back from a float.
	assign finish = (q.state == dm_port_pkg::ST_ACCESS) && data_mem_acknowledge
		&& data_bus_float_n && q.ctl_oe;

	// Banks above the last one all fall into the last bank, so the upper
	// address space never goes unselected.
	assign bank_idx   = core_addr >> bank_size_sel;
	assign bank_sel   = (|bank_idx[`DMP_ADDR_W-1:2]) ? 2'h3 : bank_idx[1:0];
	assign bank_n_new = ~(4'h1 << bank_sel);

	// Page crossing compares the page of this access with the previous one.
	assign page_new = (core_addr >> page_size_sel) != (q.last_addr >> page_size_sel);

	// ==========================================================
	// Next-state logic.
	always_comb begin
		d       = q;
		d.br_s1 = !bus_request_n;
		d.br_s2 = q.br_s1;
		d.done  = 1'h0;
		unique case (q.state)
			dm_port_pkg::ST_IDLE: begin
				if (br_sync) begin
					// Float first; the grant follows one cycle later.
					d.state   = dm_port_pkg::ST_FLOAT;
					d.addr_oe = 1'h0;
					d.data_oe = 1'h0;
					d.ctl_oe  = 1'h0;
					d.busy    = 1'h1;
				end else if (accept) begin
					d.state     = dm_port_pkg::ST_ACCESS;
					d.addr      = core_addr;
					d.last_addr = core_addr;
					d.wdata     = core_wdata;
					d.is_write  = core_write;
					d.rd_n      = core_write;
					d.wr_n      = !core_write;
					d.bank_n    = bank_n_new;
					d.page      = page_new;
					d.addr_oe   = 1'h1;
					d.ctl_oe    = 1'h1;
					d.data_oe   = core_write;
					d.busy      = 1'h1;
				end else begin
					d.addr_oe = 1'h1;
					d.ctl_oe  = 1'h1;
					d.data_oe = 1'h0;
					d.busy    = 1'h0;
				end
			end
			dm_port_pkg::ST_ACCESS: begin
				if (!data_bus_float_n) begin
					// The access is frozen, not abandoned: strobes and address are
					// kept so that it resumes where it stopped.
					d.addr_oe = 1'h0;
					d.data_oe = 1'h0;
					d.ctl_oe  = 1'h0;
				end else if (finish) begin
					d.done   = 1'h1;
					d.rd_n   = `DMP_STROBE_IDLE;
					d.wr_n   = `DMP_STROBE_IDLE;
					d.bank_n = `DMP_BANK_IDLE;
					d.page   = 1'h0;
					d.data_oe = 1'h0;
					if (!q.is_write) begin
						d.rdata = data_mem_bus_in;
					end
					if (br_sync) begin
						// The cycle in flight has ended; now give up the bus.
						d.state   = dm_port_pkg::ST_FLOAT;
						d.addr_oe = 1'h0;
						d.ctl_oe  = 1'h0;
						d.busy    = 1'h1;
					end else begin
						d.state = dm_port_pkg::ST_IDLE;
						d.busy  = 1'h0;
					end
				end else begin
					// Waiting on acknowledge, or drivers back after a float.
					d.addr_oe = 1'h1;
					d.ctl_oe  = 1'h1;
					d.data_oe = q.is_write;
				end
			end
			dm_port_pkg::ST_FLOAT: begin
				d.grant_n = 1'h0;
				d.state   = dm_port_pkg::ST_GRANT;
			end
			dm_port_pkg::ST_GRANT: begin
				if (!br_sync) begin
					d.grant_n = `DMP_GRANT_IDLE;
					d.state   = dm_port_pkg::ST_IDLE;
					d.addr_oe = 1'h1;
					d.ctl_oe  = 1'h1;
					d.busy    = 1'h0;
				end else begin
					d.grant_n = 1'h0;
				end
			end
			default: begin
				d = REG_RESET;
			end
		endcase
	end

	// ==========================================================
	// State register. The port advances on every rising edge of the free-running
	// input clock, one instruction cycle per period.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= REG_RESET;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs come straight from the record.
	assign core_busy           = q.busy;
	assign core_done           = q.done;
	assign core_rdata          = q.rdata;
	assign data_mem_addr       = q.addr;
	assign data_mem_addr_oe    = q.addr_oe;
	assign data_mem_bus_out    = q.wdata;
	assign data_mem_bus_oe     = q.data_oe;
	assign data_read_strobe_n  = q.rd_n;
	assign data_write_strobe_n = q.wr_n;
	assign data_bank_selects_n = q.bank_n;
	assign data_ctl_oe         = q.ctl_oe;
	assign data_page_cross     = q.page;
	assign bus_grant_n         = q.grant_n;

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	read_strobe_a: assert property (accept && !core_write |=> !data_read_strobe_n && data_write_strobe_n)
		else $error("read strobe not asserted for read access");

	write_strobe_a: assert property (accept && core_write |=> !data_write_strobe_n && data_read_strobe_n)
		else $error("write strobe not asserted for write access");

	wait_hold_a: assert property ((q.state == dm_port_pkg::ST_ACCESS) && !data_mem_acknowledge
		|=> (q.state == dm_port_pkg::ST_ACCESS) && !core_done && $stable(data_mem_addr))
		else $error("access ended without acknowledge");

	single_cycle_a: assert property (accept ##1 (data_mem_acknowledge && data_bus_float_n)
		|=> core_done && data_read_strobe_n && data_write_strobe_n)
		else $error("zero wait access did not finish in one cycle");

	page_flag_a: assert property (accept && page_new |=> data_page_cross)
		else $error("page crossing not flagged");

	float_oe_a: assert property ((q.state == dm_port_pkg::ST_ACCESS) && !data_bus_float_n
		|=> !data_mem_addr_oe && !data_mem_bus_oe && !data_ctl_oe)
		else $error("bus driven while float control asserted");

	float_halt_a: assert property ((q.state == dm_port_pkg::ST_ACCESS) && !data_bus_float_n
		|=> !core_done && core_busy && (q.state == dm_port_pkg::ST_ACCESS))
		else $error("floated access completed");

	grant_float_a: assert property (!bus_grant_n |-> !data_mem_addr_oe && !data_mem_bus_oe && !data_ctl_oe)
		else $error("grant given while bus still driven");

	grant_hold_a: assert property (!bus_grant_n && br_sync |=> !bus_grant_n)
		else $error("grant dropped while request held");

	grant_release_a: assert property (!bus_grant_n && !br_sync |=> bus_grant_n && !core_busy)
		else $error("grant kept after request release");

	req_sync_a: assert property (!bus_request_n ##1 !bus_request_n |=> br_sync)
		else $error("bus request not synchronised in two cycles");

	bank_one_a: assert property (accept |=> $countones(~data_bank_selects_n) == 1)
		else $error("bank select not one-hot during access");

	lanes_a: assert property (accept && core_write
		|=> data_mem_bus_out == $past(core_wdata) && data_mem_addr == $past(core_addr))
		else $error("address or data not placed on bus");

	// ==========================================================
	// Output invariants.
	// These hold on every cycle, so a broken decode shows up even in
	// scenarios that never aim at the rule in question.
	strobe_excl_a: assert property (data_read_strobe_n || data_write_strobe_n)
		else $error("read and write strobes low together");

	idle_strobe_a: assert property ((q.state == dm_port_pkg::ST_IDLE)
		|-> data_read_strobe_n && data_write_strobe_n)
		else $error("strobe low while port idle");

	done_pulse_a: assert property (core_done |=> !core_done)
		else $error("done held longer than one cycle");

	busy_strobe_a: assert property (!(data_read_strobe_n && data_write_strobe_n) |-> core_busy)
		else $error("strobe low while port not busy");

	wait_strobe_a: assert property ((q.state == dm_port_pkg::ST_ACCESS) && !data_mem_acknowledge
		|=> $stable(data_read_strobe_n) && $stable(data_write_strobe_n) && $stable(data_bank_selects_n))
		else $error("strobes moved during a wait state");

	page_clear_a: assert property (core_done |-> !data_page_cross)
		else $error("page flag kept after access end");

	float_freeze_a: assert property ((q.state == dm_port_pkg::ST_ACCESS) && !data_bus_float_n
		|=> $stable(data_mem_addr) && $stable(data_read_strobe_n) && $stable(data_write_strobe_n))
		else $error("floated access state changed");

	float_recover_a: assert property ((q.state == dm_port_pkg::ST_ACCESS) && data_bus_float_n
		&& !data_ctl_oe |=> !core_done && data_ctl_oe && data_mem_addr_oe)
		else $error("no recovery cycle after float release");

	// ==========================================================
	// Bus hand-over and lane use.
	grant_order_a: assert property ($fell(bus_grant_n) |-> !$past(data_ctl_oe))
		else $error("grant given before the bus was floated");

	grant_quiet_a: assert property (!bus_grant_n
		|-> data_read_strobe_n && data_write_strobe_n && !core_done)
		else $error("access active while bus granted");

	bus_resume_a: assert property ($rose(bus_grant_n) |-> data_mem_addr_oe && data_ctl_oe && !core_busy)
		else $error("bus not resumed after grant release");

	bank_idle_a: assert property (data_read_strobe_n && data_write_strobe_n
		|-> data_bank_selects_n == `DMP_BANK_IDLE)
		else $error("bank selected outside an access");

	write_lanes_a: assert property (!data_write_strobe_n && data_ctl_oe |-> data_mem_bus_oe)
		else $error("write data not driven during write");

	read_lanes_a: assert property (!data_read_strobe_n |-> !data_mem_bus_oe)
		else $error("data bus driven during read");

endmodule : data_memory_bus_port

`default_nettype wire

// *** logic/dm_port_defs.svh ***
// Constants of the data memory bus port: widths and reset and idle values.
`ifndef DM_PORT_DEFS_SVH
`define DM_PORT_DEFS_SVH

// ==========================================================
// Widths
`define DMP_ADDR_W 32
`define DMP_DATA_W 40
`define DMP_BANKS 4
`define DMP_SEL_W 5

// ==========================================================
// Reset and idle values
`define DMP_STROBE_IDLE 1'h1
`define DMP_BANK_IDLE 4'hF
`define DMP_GRANT_IDLE 1'h1
`define DMP_OE_RESET 1'h1

`endif

// *** logic/dm_port_pkg.sv ***
// Types of the data memory bus port: sequencer states and the state record.
`default_nettype none
`include "dm_port_defs.svh"

package dm_port_pkg;

	// ==========================================================
	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_ACCESS = 4'h2,
		ST_FLOAT  = 4'h4,
		ST_GRANT  = 4'h8
	} port_state_e;

	// ==========================================================
	// Every flip-flop of the port lives in this record.
	typedef struct packed {
		port_state_e                state;
		logic                       br_s1;
		logic                       br_s2;
		logic [`DMP_ADDR_W-1:0]     addr;
		logic [`DMP_ADDR_W-1:0]     last_addr;
		logic [`DMP_DATA_W-1:0]     wdata;
		logic [`DMP_DATA_W-1:0]     rdata;
		logic                       is_write;
		logic                       rd_n;
		logic                       wr_n;
		logic [`DMP_BANKS-1:0]      bank_n;
		logic                       page;
		logic                       addr_oe;
		logic                       data_oe;
		logic                       ctl_oe;
		logic                       grant_n;
		logic                       busy;
		logic                       done;
	} port_reg_s;

endpackage : dm_port_pkg

`default_nettype wire

// *** verification/data_mem_model.sv ***
// Behavioural data memory that answers the port's strobes after a set number of waits.
`timescale 1ns/1ns
`default_nettype none
`include "dm_port_defs.svh"

module data_mem_model (
	input  wire logic                   clk,      // Input clock.
	input  wire logic                   rd_n,     // Read strobe, low.
	input  wire logic                   wr_n,     // Write strobe, low.
	input  wire logic [`DMP_ADDR_W-1:0] addr,     // Address lines.
	input  wire logic [`DMP_DATA_W-1:0] wdata,    // Data from the port.
	input  wire logic                   wdata_oe, // Port drives the data bus.
	input  wire logic [3:0]             wait_cnt, // Wait states per access.
	output logic                        ack,      // Acknowledge, high.
	output logic [`DMP_DATA_W-1:0]      rdata     // Data toward the port.
);
	logic [`DMP_DATA_W-1:0] mem [0:255];
	int                     cnt;

	// ==========================================================
	// Answer side
	// Outputs start defined so the port never samples an unknown.
	initial begin
		ack = 1'h0;
		rdata = 40'h0;
		cnt = 0;
	end

	// Acknowledge stays low until the waits run out, then high to the strobe's end.
	always @(negedge clk) begin
		if (!rd_n || !wr_n) begin
			ack <= (cnt >= wait_cnt);
			cnt <= cnt + 1;
		end else begin
			ack <= 1'h0;
			cnt <= 0;
		end
		// Outside a read the bus toggles, so a stale word is never mistaken for data.
		rdata <= !rd_n ? mem[addr[7:0]] : ~rdata;
	end

	// A word is stored on the edge that completes the write.
	always @(posedge clk) begin
		if (!wr_n && wdata_oe && ack)
			mem[addr[7:0]] <= wdata;
	end
endmodule : data_mem_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench of the data memory bus port.
`timescale 1ns/1ns
`default_nettype none
`include "dm_port_defs.svh"

module tb_top;
	logic        clk, nrst, core_req, core_write, data_mem_acknowledge, data_bus_float_n, bus_request_n;
	logic [31:0] core_addr, data_mem_addr;
	logic [39:0] core_wdata, data_mem_bus_in, core_rdata, data_mem_bus_out;
	logic [4:0]  page_size_sel, bank_size_sel;
	logic        core_busy, core_done, data_mem_addr_oe, data_mem_bus_oe, data_read_strobe_n;
	logic        data_write_strobe_n, data_ctl_oe, data_page_cross, bus_grant_n;
	logic [3:0]  data_bank_selects_n, wait_cnt;
	int          err_total, n_tests;
	int          cyc = 0;

	data_memory_bus_port i_data_memory_bus_port (.clk, .nrst, .core_req, .core_write, .core_addr,
		.core_wdata, .page_size_sel, .bank_size_sel, .data_mem_acknowledge, .data_bus_float_n,
		.bus_request_n, .data_mem_bus_in, .core_busy, .core_done, .core_rdata, .data_mem_addr,
		.data_mem_addr_oe, .data_mem_bus_out, .data_mem_bus_oe, .data_read_strobe_n,
		.data_write_strobe_n, .data_bank_selects_n, .data_ctl_oe, .data_page_cross, .bus_grant_n);

	// Strobes go high when the port lets go of them, as their pull-ups would make them.
	data_mem_model i_data_mem_model (.clk, .rd_n(data_read_strobe_n | !data_ctl_oe),
		.wr_n(data_write_strobe_n | !data_ctl_oe),
		.addr(data_mem_addr), .wdata(data_mem_bus_out), .wdata_oe(data_mem_bus_oe), .wait_cnt,
		.ack(data_mem_acknowledge), .rdata(data_mem_bus_in));

	// ==========================================================
	// Checking and closing
	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			err_total++;
		end
	endtask : chk

	task automatic give_verdict;
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// One access from a falling edge; strobes, address and selects are judged every cycle.
	task automatic access(input logic wr, input logic [31:0] a, input logic [39:0] d, input int w, input logic pc);
		int         n;
		logic [1:0] b;
		n = 0;
		b = (a >> 4) > 3 ? 2'h3 : a[5:4];
		wait_cnt = 4'(w);
		core_write = wr;
		core_addr = a;
		core_wdata = d;
		core_req = 1'h1;
		@(negedge clk);
		chk("page", data_page_cross, pc);
		while (core_done !== 1'h1 && n < 20) begin
			chk("rd", data_read_strobe_n, wr);
			chk("wr", data_write_strobe_n, !wr);
			chk("addr", data_mem_addr, a);
			chk("bank", data_bank_selects_n, 4'(~(4'h1 << b)));
			chk("bus_oe", data_mem_bus_oe, wr);
			chk("busy", core_busy, 1'h1);
			if (wr) chk("wdata", data_mem_bus_out, d);
			n++;
			@(negedge clk);
		end
		core_req = 1'h0;
		chk("cycles", 40'(n), 40'(1 + w));
		chk("idle", core_busy, 1'h0);
		// One edge passes so the next call never lowers and raises the request at once.
		@(negedge clk);
	endtask : access

	// ==========================================================
	// Scenarios
	// Every bank, saturation above bank 3, page changes, read back and waits.
	task automatic t_banks;
		access(1'h1, 32'h03, 40'h1122334400, 0, 1'h0);
		access(1'h1, 32'h13, 40'hA1B2C3D45E, 0, 1'h1);
		access(1'h1, 32'h23, 40'h5566778899, 1, 1'h1);
		access(1'h1, 32'h33, 40'h0F0F0F0F01, 0, 1'h1);
		access(1'h1, 32'h45, 40'hCAFE0123AB, 0, 1'h1);
		access(1'h0, 32'h13, 40'h0, 0, 1'h1);
		chk("rdata", core_rdata, 40'hA1B2C3D45E);
		access(1'h0, 32'h45, 40'h0, 3, 1'h1);
		chk("rdata_w", core_rdata, 40'hCAFE0123AB);
		$display("Test banks done");
	endtask : t_banks

	// Float raised in mid-read: lines let go, the access waits and then completes.
	task automatic t_float;
		int n;
		n = 0;
		wait_cnt = 4'h2;
		core_write = 1'h0;
		core_addr = 32'h23;
		core_req = 1'h1;
		@(negedge clk);
		data_bus_float_n = 1'h0;
		repeat (2) @(negedge clk);
		chk("addr_oe", data_mem_addr_oe, 1'h0);
		chk("ctl_oe", data_ctl_oe, 1'h0);
		chk("bus_oe", data_mem_bus_oe, 1'h0);
		chk("fl_done", core_done, 1'h0);
		chk("fl_busy", core_busy, 1'h1);
		data_bus_float_n = 1'h1;
		while (core_done !== 1'h1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		core_req = 1'h0;
		chk("fl_end", core_done, 1'h1);
		chk("fl_rdata", core_rdata, 40'h5566778899);
		@(negedge clk);
		$display("Test float done");
	endtask : t_float

	// Bus request during a write: the write finishes, then float and grant until release.
	task automatic t_grant;
		int n;
		int d;
		n = 0;
		d = 0;
		bus_request_n = 1'h0;
		wait_cnt = 4'h0;
		core_write = 1'h1;
		core_addr = 32'h05;
		core_wdata = 40'h123456789A;
		core_req = 1'h1;
		while (bus_grant_n !== 1'h0 && n < 12) begin
			@(negedge clk);
			n++;
			if (core_done === 1'h1) begin
				d++;
				core_req = 1'h0;
			end
		end
		chk("fin_cycle", 40'(d), 40'h1);
		chk("g_addr_oe", data_mem_addr_oe, 1'h0);
		chk("g_ctl_oe", data_ctl_oe, 1'h0);
		core_write = 1'h0;
		core_req = 1'h1;
		repeat (8) begin
			@(negedge clk);
			chk("g_hold", bus_grant_n, 1'h0);
			chk("g_nodone", core_done, 1'h0);
			chk("g_busy", core_busy, 1'h1);
		end
		bus_request_n = 1'h1;
		n = 0;
		while (core_done !== 1'h1 && n < 12) begin
			@(negedge clk);
			n++;
		end
		core_req = 1'h0;
		chk("g_free", bus_grant_n, 1'h1);
		chk("g_end", core_done, 1'h1);
		chk("g_rdata", core_rdata, 40'h123456789A);
		$display("Test grant done");
	endtask : t_grant

	// ==========================================================
	// Clock, hang guard and main sequence
	always #4 clk = ~clk;

	// Whole run needs under a hundred cycles; far beyond that means a hang.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			give_verdict;
		end
	end

	initial begin
		clk = 1'h0;
		nrst = 1'h0;
		core_req = 1'h0;
		core_write = 1'h0;
		core_addr = 32'h0;
		core_wdata = 40'h0;
		page_size_sel = 5'h4;
		bank_size_sel = 5'h4;
		data_bus_float_n = 1'h1;
		bus_request_n = 1'h1;
		wait_cnt = 4'h0;
		err_total = 0;
		n_tests = 0;
		repeat (6) @(negedge clk);
		nrst = 1'h1;
		@(negedge clk);
		chk("rst_sel", data_bank_selects_n, 4'hF);
		chk("rst_grant", bus_grant_n, 1'h1);
		t_banks;
		t_float;
		t_grant;
		give_verdict;
	end
endmodule : tb_top
`default_nettype wire
